// File: logic/ber_mon_pkg.sv
package ber_mon_pkg;
	// widths of the settings and of the error tally
	localparam int BYTE_W = 16;
	localparam int CNT_W = 16;
	localparam int BIT_W = 3;
	localparam logic [BIT_W-1:0] LAST_BIT = 3'h7;
	localparam logic [BYTE_W-1:0] BYTE_ZERO = 16'h0000;
	localparam logic [BYTE_W-1:0] BYTE_ONE = 16'h0001;
	localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
	localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
	localparam logic [BIT_W-1:0] BIT_ZERO = 3'h0;
	localparam logic [BIT_W-1:0] BIT_ONE = 3'h1;
	// setting handshake states (core side)
	typedef enum logic [0:0] {
		CFG_IDLE = 1'b0,
		CFG_WAIT = 1'b1
	} cfg_state_t;
endpackage

// File: logic/ber_monitor_outputs.sv
`timescale 1ns/1ns
module ber_monitor_outputs (
	// core side
	input wire logic i_core_clk,
	input wire logic i_resetn,
	input wire logic [ber_mon_pkg::BYTE_W-1:0] i_pattern_len_bytes,
	input wire logic [ber_mon_pkg::BYTE_W-1:0] i_marker_byte_position_setting,
	output logic [ber_mon_pkg::CNT_W-1:0] o_error_count,
	output logic o_cfg_busy,
	// received link
	input wire logic i_rx_clk,
	input wire logic i_rx_data,
	input wire logic i_ref_data,
	input wire logic i_error_inhibit,
	// monitor outputs
	output logic o_clk_mon,
	output logic o_data_mon,
	output logic o_frame_marker,
	output logic o_error_pulse_output
);
	localparam int BW = ber_mon_pkg::BYTE_W;
	localparam int CW = ber_mon_pkg::CNT_W;

	function automatic logic [CW-1:0] gray2bin(input logic [CW-1:0] g);
		logic [CW-1:0] b;
		b = '0;
		b[CW-1] = g[CW-1];
		for (int i = CW - 2; i >= 0; i--) begin
			b[i] = b[i+1] ^ g[i];
		end
		return b;
	endfunction

	// next byte index, shared by the wrap test and the step
	function automatic logic [BW-1:0] inc_byte(input logic [BW-1:0] v);
		return v + ber_mon_pkg::BYTE_ONE;
	endfunction

	// ****************************************************
	// core side: settings handed over by toggle handshake
	// ****************************************************
	ber_mon_pkg::cfg_state_t cfg_st_q, cfg_st_d;
	logic [BW-1:0] len_q, len_d, pos_q, pos_d;
	logic req_q, req_d;
	logic ack_s1_q, ack_s2_q;
	logic [CW-1:0] gcnt_s1_q, gcnt_s2_q;
	logic [CW-1:0] cnt_q, cnt_d;
	logic busy_d;
	// link-side flops that the core synchronisers sample
	logic rx_ack_q;
	logic [CW-1:0] gcnt_q;

	always_comb begin
		cfg_st_d = cfg_st_q;
		len_d = len_q;
		pos_d = pos_q;
		req_d = req_q;
		case (cfg_st_q)
			ber_mon_pkg::CFG_IDLE: begin
				if (i_pattern_len_bytes != len_q ||
					i_marker_byte_position_setting != pos_q) begin
					len_d = i_pattern_len_bytes;
					pos_d = i_marker_byte_position_setting;
					req_d = ~req_q;
					cfg_st_d = ber_mon_pkg::CFG_WAIT;
				end
			end
			default: begin
				// words stay frozen until the link side acknowledges
				if (ack_s2_q == req_q) begin
					cfg_st_d = ber_mon_pkg::CFG_IDLE;
				end
			end
		endcase
		busy_d = (cfg_st_d == ber_mon_pkg::CFG_WAIT);
		cnt_d = gray2bin(gcnt_s2_q);
	end

	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			cfg_st_q <= ber_mon_pkg::CFG_IDLE;
			len_q <= ber_mon_pkg::BYTE_ZERO;
			pos_q <= ber_mon_pkg::BYTE_ZERO;
			req_q <= 1'b0;
			ack_s1_q <= 1'b0;
			ack_s2_q <= 1'b0;
			gcnt_s1_q <= ber_mon_pkg::CNT_ZERO;
			gcnt_s2_q <= ber_mon_pkg::CNT_ZERO;
			cnt_q <= ber_mon_pkg::CNT_ZERO;
			o_cfg_busy <= 1'b0;
		end else begin
			cfg_st_q <= cfg_st_d;
			len_q <= len_d;
			pos_q <= pos_d;
			req_q <= req_d;
			ack_s1_q <= rx_ack_q;
			ack_s2_q <= ack_s1_q;
			gcnt_s1_q <= gcnt_q;
			gcnt_s2_q <= gcnt_s1_q;
			cnt_q <= cnt_d;
			o_cfg_busy <= busy_d;
		end
	end

	assign o_error_count = cnt_q;

	// ****************************************************
	// link side, on the received clock
	// ****************************************************
	// a clock replica cannot come from a flop without halving it
	assign o_clk_mon = i_rx_clk;

	// ****************************************************
	// link reset release
	// ****************************************************
	// release is re-timed so no link flop leaves reset mid-edge
	logic rst_s1_q, rst_s2_q;
	always_ff @(posedge i_rx_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			rst_s1_q <= 1'b0;
			rst_s2_q <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_s2_q <= rst_s1_q;
		end
	end
	wire rx_rstn = rst_s2_q;

	// ****************************************************
	// settings, frame position and error detection
	// ****************************************************
	logic req_s1_q, req_s2_q, rx_ack_d;
	logic [BW-1:0] rlen_q, rlen_d, rpos_q, rpos_d;
	logic [BW-1:0] byte_q, byte_d;
	logic [ber_mon_pkg::BIT_W-1:0] bit_q, bit_d;
	logic inh_s1_q, inh_s2_q;
	logic data_q, err_d, err_hi_d, err_hi_q, err_lo_q;
	logic mark_d, mark_q;
	logic [CW-1:0] bcnt_q, bcnt_d, gcnt_d;

	always_comb begin
		rx_ack_d = rx_ack_q;
		rlen_d = rlen_q;
		rpos_d = rpos_q;
		if (req_s2_q != rx_ack_q) begin
			rlen_d = len_q;
			rpos_d = pos_q;
			rx_ack_d = req_s2_q;
		end
		// bit and byte position inside the pattern frame
		bit_d = bit_q + ber_mon_pkg::BIT_ONE;
		byte_d = byte_q;
		if (bit_q == ber_mon_pkg::LAST_BIT) begin
			bit_d = ber_mon_pkg::BIT_ZERO;
			if (inc_byte(byte_q) >= rlen_q) begin
				byte_d = ber_mon_pkg::BYTE_ZERO;
			end else begin
				byte_d = inc_byte(byte_q);
			end
		end
		mark_d = (byte_d == rpos_q);
		// a mismatch only counts while inhibit is low
		err_d = (i_rx_data ^ i_ref_data) & ~inh_s2_q;
		// one toggle per error; the falling-edge copy closes each pulse
		err_hi_d = err_hi_q ^ err_d;
		bcnt_d = err_d ? bcnt_q + ber_mon_pkg::CNT_ONE : bcnt_q;
		gcnt_d = bcnt_d ^ (bcnt_d >> 1);
	end

	always_ff @(posedge i_rx_clk or negedge rx_rstn) begin
		if (!rx_rstn) begin
			req_s1_q <= 1'b0;
			req_s2_q <= 1'b0;
			rx_ack_q <= 1'b0;
			rlen_q <= ber_mon_pkg::BYTE_ZERO;
			rpos_q <= ber_mon_pkg::BYTE_ZERO;
			byte_q <= ber_mon_pkg::BYTE_ZERO;
			bit_q <= ber_mon_pkg::BIT_ZERO;
			inh_s1_q <= 1'b1;
			inh_s2_q <= 1'b1;
			data_q <= 1'b0;
			mark_q <= 1'b0;
			err_hi_q <= 1'b0;
			bcnt_q <= ber_mon_pkg::CNT_ZERO;
			gcnt_q <= ber_mon_pkg::CNT_ZERO;
		end else begin
			req_s1_q <= req_q;
			req_s2_q <= req_s1_q;
			rx_ack_q <= rx_ack_d;
			rlen_q <= rlen_d;
			rpos_q <= rpos_d;
			byte_q <= byte_d;
			bit_q <= bit_d;
			inh_s1_q <= i_error_inhibit;
			inh_s2_q <= inh_s1_q;
			data_q <= i_rx_data;
			mark_q <= mark_d;
			err_hi_q <= err_hi_d;
			bcnt_q <= bcnt_d;
			gcnt_q <= gcnt_d;
		end
	end

	// ****************************************************
	// return-to-zero shaping of the error pulse
	// ****************************************************
	// the falling edge catches up with the toggle, ending the pulse at
	// mid-bit; errors on back-to-back bits each toggle, so each pulses
	always_ff @(negedge i_rx_clk or negedge rx_rstn) begin
		if (!rx_rstn) begin
			err_lo_q <= 1'b0;
		end else begin
			err_lo_q <= err_hi_q;
		end
	end

	// ****************************************************
	// monitor outputs
	// ****************************************************
	assign o_data_mon = data_q;
	assign o_frame_marker = mark_q;
	assign o_error_pulse_output = err_hi_q ^ err_lo_q;
endmodule

// File: tb/ber_mon_assertions.sv
`timescale 1ns/1ns
module ber_mon_assertions (
	input wire logic i_core_clk, i_resetn, i_rx_clk, i_rx_data,
	input wire logic i_ref_data, i_error_inhibit, o_clk_mon,
	input wire logic o_data_mon, o_frame_marker, o_error_pulse_output
);
	// long history, so the inhibit synchroniser has surely settled
	logic [5:0] inh_q;
	logic err_q;
	// the marker runs on one-byte defaults until the first setting lands
	logic [3:0] age_q;
	always_ff @(posedge i_rx_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			inh_q <= 6'h3f;
			err_q <= 1'b0;
			age_q <= 4'h0;
		end else begin
			inh_q <= {inh_q[4:0], i_error_inhibit};
			err_q <= i_rx_data != i_ref_data;
			if (age_q != 4'hf) begin
				age_q <= age_q + 4'h1;
			end
		end
	end
	sequence s_byte;
		o_frame_marker [*8] ##1 !o_frame_marker;
	endsequence
	a_clk_copy: assert property (@(posedge i_core_clk)
		disable iff (!i_resetn) o_clk_mon == i_rx_clk) else $error("clk");
	a_data_retime: assert property (@(posedge i_rx_clk)
		disable iff (!i_resetn) $past(i_resetn, 4) |->
		o_data_mon == $past(i_rx_data)) else $error("data");
	a_marker_byte: assert property (@(posedge i_rx_clk)
		disable iff (!i_resetn) age_q == 4'hf && $rose(o_frame_marker)
		|-> s_byte) else $error("marker");
	a_inhibit_gate: assert property (@(negedge i_rx_clk)
		disable iff (!i_resetn) &inh_q[3:0] |-> !o_error_pulse_output)
		else $error("inhibit");
	a_pulse_due: assert property (@(negedge i_rx_clk)
		disable iff (!i_resetn) err_q && inh_q == 6'h00 |->
		o_error_pulse_output) else $error("missed pulse");
	a_pulse_cause: assert property (@(negedge i_rx_clk)
		disable iff (!i_resetn) o_error_pulse_output |-> err_q)
		else $error("extra pulse");
	a_pulse_rz: assert property (@(posedge i_rx_clk)
		disable iff (!i_resetn) !o_error_pulse_output) else $error("rz");
endmodule
bind ber_monitor_outputs ber_mon_assertions i_chk (.i_core_clk, .i_resetn,
	.i_rx_clk, .i_rx_data, .i_ref_data, .i_error_inhibit, .o_clk_mon,
	.o_data_mon, .o_frame_marker, .o_error_pulse_output);

// File: tb/ber_monitor_outputs_bench.sv
`timescale 1ns/1ns
module ber_monitor_outputs_bench;
	logic i_core_clk = 1'b0;
	logic i_resetn = 1'b0;
	logic i_error_inhibit = 1'b0;
	logic inject = 1'b0;
	logic rx_clk, rx_data, ref_data, marker, busy, pulse;
	logic [ber_mon_pkg::CNT_W-1:0] cnt;
	logic [15:0] len_set = 16'h0004;
	logic [15:0] pos_set = 16'h0002;
	logic [15:0] exp_errs = 16'h0000;
	int sent, n_mismatch = 0, comparisons = 0, cycles = 0;
	int n_pulse = 0, rx_edges = 0;
	ber_src i_src (.i_inject(inject), .o_clk(rx_clk), .o_data(rx_data),
		.o_ref(ref_data), .o_sent(sent));
	ber_monitor_outputs i_dut (.i_core_clk, .i_resetn,
		.i_pattern_len_bytes(len_set),
		.i_marker_byte_position_setting(pos_set),
		.o_error_count(cnt), .o_cfg_busy(busy), .i_rx_clk(rx_clk),
		.i_rx_data(rx_data), .i_ref_data(ref_data), .i_error_inhibit,
		.o_clk_mon(), .o_data_mon(), .o_frame_marker(marker),
		.o_error_pulse_output(pulse));
	initial forever #20 i_core_clk = ~i_core_clk;
	// every rising edge of the pulse output is one reported error
	always @(posedge pulse) n_pulse++;
	always @(posedge rx_clk) rx_edges++;
	task automatic check(string what, logic [15:0] exp, logic [15:0] got);
		comparisons++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic test_errors(logic inh);
		int s0, p0;
		logic [15:0] exp_p;
		@(posedge i_core_clk) i_error_inhibit <= inh;
		repeat (8) @(posedge rx_clk);
		s0 = sent;
		p0 = n_pulse;
		@(posedge i_core_clk) inject <= 1'b1;
		repeat (5) @(posedge rx_clk);
		@(posedge i_core_clk) inject <= 1'b0;
		repeat (8) @(posedge rx_clk);
		if (!inh) begin
			exp_errs = exp_errs + 16'(sent - s0);
		end
		exp_p = inh ? 16'h0000 : 16'(sent - s0);
		check("count", exp_errs, cnt);
		check("pulses", exp_p, 16'(n_pulse - p0));
		check("injected", 16'h0001, 16'(sent - s0 >= 2));
		$display("errors done, inhibit %b", inh);
	endtask
	task automatic wait_marker(logic level);
		do begin
			@(posedge rx_clk);
			#1;
		end while (marker !== level);
	endtask
	task automatic test_marker();
		int t0;
		int rises = 0;
		logic last;
		// four bytes of eight bits: the low gap spans the other three
		wait_marker(1'b1);
		wait_marker(1'b0);
		t0 = rx_edges;
		wait_marker(1'b1);
		check("gap", 16'h0018, 16'(rx_edges - t0));
		// move the marker while the counter sits past the old byte
		wait_marker(1'b0);
		t0 = rx_edges;
		@(posedge i_core_clk) pos_set <= 16'h0001;
		@(posedge i_core_clk);
		#1;
		check("busy", 16'h0001, 16'(busy));
		wait_marker(1'b1);
		check("moved gap", 16'h0010, 16'(rx_edges - t0));
		check("idle", 16'h0000, 16'(busy));
		last = marker;
		repeat (128) begin
			@(posedge rx_clk);
			#1;
			rises += int'(marker && !last);
			last = marker;
		end
		check("marker", 16'h0004, 16'(rises));
		$display("marker done");
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	always @(posedge i_core_clk) begin
		cycles++;
		// about two and a half times the longest expected run
		if (cycles == 2500) begin
			n_mismatch++;
			tally_and_finish();
		end
	end
	initial begin
		repeat (3) @(posedge i_core_clk);
		i_resetn <= 1'b1;
		// the link side needs its own clock edges to leave reset
		repeat (40) @(posedge rx_clk);
		test_errors(1'b0);
		test_errors(1'b1);
		test_errors(1'b0);
		test_marker();
		tally_and_finish();
	end
endmodule

// File: tb/ber_src.sv
`timescale 1ns/1ns
module ber_src (
	input wire logic i_inject,
	output logic o_clk = 1'b0,
	output logic o_data = 1'b0,
	output logic o_ref = 1'b0,
	output int o_sent = 0
);
	logic [6:0] lfsr = 7'h5a;
	initial forever begin
		#7 o_clk = 1'b1;
		#62 o_clk = 1'b0;
		#56;
	end
	// data moves mid-bit so it is settled at the sampling edge
	always @(negedge o_clk) begin
		lfsr <= {lfsr[5:0], lfsr[6] ^ lfsr[5]};
		o_data <= lfsr[6];
		o_ref <= lfsr[6] ^ i_inject;
		o_sent <= o_sent + int'(i_inject);
	end
endmodule
